// File: dpa_params.svh
/*
  Constants for the dual parallel adapter: port locations, control fields, timing counts.
  Assumes inclusion by both end modules and the bench.
*/
// What this block does
// RULE1: First adapter decodes 0x80 to 0x83.
// RULE2: Second adapter: side A only, 0x8A/0x8B unused.
// RULE3: Host initialises every port before transfers.
// RULE4: Init step one: write zero to control.
// RULE5: Direction byte: one is output, zero input.
// RULE6: Init step three: write 0x34 to control.
// RULE7: Data read gives inputs; write drives outputs.
// RULE8: Byte host bus, two byte peripheral buses.
// RULE9: Four interrupt lines, two usable as outputs.
// RULE10: Control bit 2 selects direction or data.
// RULE11: Active-low reset zeroes every register bit.
// RULE12: Respond only when selects match; hold stable.
// RULE13: Register selects plus control choose register.
// RULE14: Data read clears flags until deselected.
`ifndef DPA_PARAMS_SVH
`define DPA_PARAMS_SVH
`define DPA_P1_A_DATA 8'h80
`define DPA_P1_A_CTRL 8'h81
`define DPA_P1_B_DATA 8'h82
`define DPA_P1_B_CTRL 8'h83
`define DPA_P2_A_DATA 8'h88
`define DPA_P2_A_CTRL 8'h89
`define DPA_P2_UNUSED_LO 8'h8A
`define DPA_P2_UNUSED_HI 8'h8B
`define DPA_CTRL_INIT 8'h00
`define DPA_CTRL_RUN 8'h34
`define DPA_CR_IRQ1_EN 0
`define DPA_CR_IRQ1_EDGE 1
`define DPA_CR_DATA_SEL 2
`define DPA_CR_C2_EN 3
`define DPA_CR_C2_EDGE 4
`define DPA_CR_C2_OUT 5
`define DPA_CR_FLAG2 6
`define DPA_CR_FLAG1 7
`define DPA_E_HIGH_NS 500
`define DPA_CLK_NS 50
`define DPA_E_CYC ((`DPA_E_HIGH_NS + `DPA_CLK_NS - 1) / `DPA_CLK_NS)
`define DPA_AHB_CMD 32'h0000_0000
`define DPA_AHB_WDATA 32'h0000_0004
`define DPA_AHB_STAT 32'h0000_0008
`define DPA_AHB_RDATA 32'h0000_000C
`define DPA_AHB_IRQ_STAT 32'h0000_0010
`define DPA_AHB_IRQ_MASK 32'h0000_0014
`define DPA_CMD_GO 8
`define DPA_CMD_READ 9
`define DPA_ST_BUSY 0
`define DPA_IRQ_DONE 0
`define DPA_IRQ_ADAPTER 1
`endif

// File: dpa_pkg.sv
/*
  Types shared by the adapter and its host controller.
  Assumes dpa_params.svh beside it.
*/
package dpa_pkg;
  typedef enum logic [3:0] {
    DPA_IDLE = 4'b0001,
    DPA_SETUP = 4'b0010,
    DPA_STROBE = 4'b0100,
    DPA_DONE = 4'b1000
  } dpa_host_state_t;
  typedef logic [7:0] dpa_byte_t;
endpackage

// File: dpa_bus_if.sv
/*
  Host bus between the bus controller and the dual adapter card.
  Assumes one clock hclk; the host controller takes the device data byte only while dev_doe is set.
*/
`timescale 1ns/100ps
interface dpa_bus_if;
  logic enable;
  logic rd_wr;
  logic [7:0] addr;
  logic [7:0] host_dout;
  logic [7:0] dev_dout;
  logic dev_doe;
  logic irq_n;
  logic reset_n;
  modport host (
    output enable,
    output rd_wr,
    output addr,
    output host_dout,
    output reset_n,
    input dev_dout,
    input dev_doe,
    input irq_n
  );
  modport dev (
    input enable,
    input rd_wr,
    input addr,
    input host_dout,
    input reset_n,
    output dev_dout,
    output dev_doe,
    output irq_n
  );
endinterface // dpa_bus_if

// File: dpa_card.sv
/*
  Dual parallel adapter card: adapter 1 with sides A and B, adapter 2 with side A.
  Assumes host bus signals synchronous to hclk; one enable pulse per access.
*/
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/100ps
`include "dpa_params.svh"
module dpa_card
  import dpa_pkg::*;
(
  // Clock and bus
  input wire logic hclk,
  input wire logic hresetn,
  dpa_bus_if.dev bus,
  // Peripheral lines, 0..7 p1 side A, 8..15 p1 side B, 16..23 p2 side A
  input wire logic [23:0] line_in,
  output logic [23:0] line_out,
  output logic [23:0] line_oe,
  // Interrupt and control lines per side
  input wire logic [2:0] irq1_in,
  input wire logic [2:0] ctrl2_in,
  output logic [2:0] ctrl2_out,
  output logic [2:0] ctrl2_oe,
  output logic [2:0] side_irq_n
);
  logic rst_n;
  logic en_q;
  logic [7:0] rdata_q, rdata_d;
  logic [2:0][7:0] rd_side;
  logic hit;
  logic [1:0] side;
  logic rs_data;
  logic rise;

  assign rst_n = hresetn & bus.reset_n; // [RULE11]
  assign rise = bus.enable & ~en_q;

  // Address decode of both adapters
  always_comb
  begin
    hit = 1'b1;
    side = 2'd0;
    rs_data = ~bus.addr[0];
    unique case ({bus.addr[7:1], 1'b0})
      `DPA_P1_A_DATA: side = 2'd0; // [RULE1] [RULE13]
      `DPA_P1_B_DATA: side = 2'd1; // [RULE1]
      `DPA_P2_A_DATA: side = 2'd2; // [RULE2]
      default: hit = 1'b0; // [RULE2]
    endcase
  end

  // One block per side: 0 and 1 on the first adapter, 2 on the second
  for (genvar s = 0; s < 3; s++)
  begin : g_side
    logic [7:0] ddr_q, ddr_d, odr_q, odr_d;
    logic [5:0] cr_q, cr_d;
    logic c2o_q, c2o_d;
    logic c1_q, c1_d, c2_q, c2_d, arm_q, arm_d;
    logic f1_q, f1_d, f2_q, f2_d;
    logic acc;

    assign acc = rise & hit & (side == 2'(s));

    // Direction and output registers behind the shared data location
    always_comb
    begin
      ddr_d = ddr_q;
      odr_d = odr_q;
      if (acc && !bus.rd_wr && rs_data)
      begin
        if (cr_q[`DPA_CR_DATA_SEL])
          odr_d = bus.host_dout; // [RULE7]
        else
          ddr_d = bus.host_dout; // [RULE5] [RULE10]
      end
    end

    always_ff @(posedge hclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        ddr_q <= '0;
        odr_q <= '0;
      end
      else
      begin
        ddr_q <= ddr_d;
        odr_q <= odr_d;
      end
    end

    // Control register; the control line level is kept in its own flip-flop
    always_comb
    begin
      cr_d = cr_q;
      if (acc && !bus.rd_wr && !rs_data)
        cr_d = bus.host_dout[5:0]; // [RULE4] [RULE6]
      c2o_d = cr_d[`DPA_CR_C2_EDGE] & cr_d[`DPA_CR_C2_EN];
    end

    always_ff @(posedge hclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        cr_q <= '0;
        c2o_q <= 1'b0;
      end
      else
      begin
        cr_q <= cr_d;
        c2o_q <= c2o_d;
      end
    end

    // Edge sense and flags; a data read clears, a deselected pulse re-arms
    always_comb
    begin
      c1_d = irq1_in[s];
      c2_d = ctrl2_in[s];
      arm_d = arm_q;
      f1_d = f1_q;
      f2_d = f2_q;
      if (rise && !hit)
        arm_d = 1'b1; // [RULE14]
      if (arm_q && (c1_q != irq1_in[s]) && (irq1_in[s] == cr_q[`DPA_CR_IRQ1_EDGE]))
        f1_d = 1'b1; // [RULE9]
      if (arm_q && !cr_q[`DPA_CR_C2_OUT] && (c2_q != ctrl2_in[s])
          && (ctrl2_in[s] == cr_q[`DPA_CR_C2_EDGE]))
        f2_d = 1'b1; // [RULE9]
      if (acc && bus.rd_wr && rs_data && cr_q[`DPA_CR_DATA_SEL])
      begin
        f1_d = 1'b0; // [RULE14]
        f2_d = 1'b0;
        arm_d = 1'b0;
      end
    end

    always_ff @(posedge hclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        c1_q <= 1'b0;
        c2_q <= 1'b0;
        arm_q <= 1'b0;
        f1_q <= 1'b0;
        f2_q <= 1'b0;
      end
      else
      begin
        c1_q <= c1_d;
        c2_q <= c2_d;
        arm_q <= arm_d;
        f1_q <= f1_d;
        f2_q <= f2_d;
      end
    end

    // Control reads carry the flags on top; data reads mix pins and driven bits
    assign rd_side[s] = !rs_data ? {f1_q, f2_q, cr_q}
      : cr_q[`DPA_CR_DATA_SEL] ? ((line_in[s*8 +: 8] & ~ddr_q) | (odr_q & ddr_q)) // [RULE7]
      : ddr_q; // [RULE10]
    assign line_out[s*8 +: 8] = odr_q; // [RULE8]
    assign line_oe[s*8 +: 8] = ddr_q; // [RULE5]
    assign ctrl2_oe[s] = cr_q[`DPA_CR_C2_OUT]; // [RULE9]
    assign ctrl2_out[s] = c2o_q;
    assign side_irq_n[s] = ~((f1_q & cr_q[`DPA_CR_IRQ1_EN])
      | (f2_q & cr_q[`DPA_CR_C2_EN] & ~cr_q[`DPA_CR_C2_OUT]));
  end

  // Read byte is registered; the host samples it late in the enable pulse
  always_comb
  begin
    rdata_d = 8'h00;
    if (hit)
    begin
      unique case (side)
        2'd0: rdata_d = rd_side[0]; // [RULE13]
        2'd1: rdata_d = rd_side[1];
        2'd2: rdata_d = rd_side[2];
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      en_q <= bus.enable;
      rdata_q <= rdata_d;
    end
  end

  assign bus.dev_dout = rdata_q;
  assign bus.dev_doe = bus.enable & bus.rd_wr & hit; // [RULE12]
  assign bus.irq_n = &side_irq_n;
endmodule // dpa_card

// File: dpa_host.sv
/*
  Host controller: AHB-Lite slave registers turned into single enable-pulse accesses.
  Assumes one AHB master; single word transfers; response always OKAY.
*/
`timescale 1ns/100ps
`include "dpa_params.svh"
module dpa_host
  import dpa_pkg::*;
(
  // AHB-Lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Interrupt to software
  output logic irq,
  // Adapter bus
  dpa_bus_if.host bus
);
  localparam int E_CYC = `DPA_E_CYC;
  dpa_host_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] addr_q, addr_d, wd_q, wd_d, rd_q, rd_d;
  logic rw_q, rw_d;
  logic [1:0] ist_q, ist_d, imask_q, imask_d;
  logic [31:0] a_q, a_d;
  logic wr_q, wr_d;
  logic done;
  logic [31:0] hrdata_q, hrdata_d;

  assign done = (st_q == DPA_DONE);

  // Bus slave and command registers
  always_comb
  begin
    a_d = a_q;
    wr_d = 1'b0;
    addr_d = addr_q;
    wd_d = wd_q;
    rw_d = rw_q;
    imask_d = imask_q;
    ist_d = ist_q;
    st_d = st_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    if (hsel && hready && htrans[1])
    begin
      a_d = haddr;
      wr_d = hwrite;
    end
    unique case (st_q)
      DPA_IDLE:
        if (wr_q && a_q == `DPA_AHB_CMD && hwdata[`DPA_CMD_GO])
        begin
          addr_d = hwdata[7:0];
          rw_d = hwdata[`DPA_CMD_READ];
          st_d = DPA_SETUP;
        end
      DPA_SETUP:
      begin
        cnt_d = 4'(E_CYC);
        st_d = DPA_STROBE; // [RULE12]
      end
      DPA_STROBE:
      begin
        cnt_d = cnt_q - 4'd1;
        if (cnt_q == 4'd1)
        begin
          rd_d = bus.dev_doe ? bus.dev_dout : 8'h00;
          st_d = DPA_DONE;
        end
      end
      DPA_DONE:
        st_d = DPA_IDLE;
      default:
        st_d = DPA_IDLE;
    endcase
    if (wr_q && a_q == `DPA_AHB_WDATA)
      wd_d = hwdata[7:0]; // [RULE3] [RULE4] [RULE5] [RULE6]
    if (wr_q && a_q == `DPA_AHB_IRQ_MASK)
      imask_d = hwdata[1:0];
    if (wr_q && a_q == `DPA_AHB_IRQ_STAT)
      ist_d = ist_q & ~hwdata[1:0];
    if (done)
      ist_d[`DPA_IRQ_DONE] = 1'b1;
    if (!bus.irq_n)
      ist_d[`DPA_IRQ_ADAPTER] = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= DPA_IDLE;
      cnt_q <= '0;
      addr_q <= '0;
      wd_q <= '0;
      rd_q <= '0;
      rw_q <= 1'b0;
      ist_q <= '0;
      imask_q <= '0;
      a_q <= '0;
      wr_q <= 1'b0;
      hrdata_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      rw_q <= rw_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      a_q <= a_d;
      wr_q <= wr_d;
      hrdata_q <= hrdata_d;
    end
  end

  // Read data is registered at the address phase and stands for the whole data phase
  always_comb
  begin
    hrdata_d = hrdata_q;
    if (hsel && hready && htrans[1] && !hwrite)
    begin
      unique case (haddr)
        `DPA_AHB_CMD: hrdata_d = {22'h0, rw_q, 1'b0, addr_q};
        `DPA_AHB_WDATA: hrdata_d = {24'h0, wd_q};
        `DPA_AHB_STAT: hrdata_d = {31'h0, (st_q != DPA_IDLE)};
        `DPA_AHB_RDATA: hrdata_d = {24'h0, rd_q};
        `DPA_AHB_IRQ_STAT: hrdata_d = {30'h0, ist_q};
        `DPA_AHB_IRQ_MASK: hrdata_d = {30'h0, imask_q};
        default: hrdata_d = 32'h0000_0000;
      endcase
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(ist_q & imask_q);
  assign bus.enable = (st_q == DPA_STROBE);
  assign bus.rd_wr = rw_q;
  assign bus.addr = addr_q; // [RULE12]
  assign bus.host_dout = wd_q;
  assign bus.reset_n = hresetn;
endmodule // dpa_host

// File: dpa_chk_props.sv
/*
  Checker for the adapter bus between the host controller and the card.
  Assumes the bench places it beside the bus interface, in the hclk domain.
*/
`timescale 1ns/100ps
module dpa_chk_props (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Adapter bus
  input wire logic enable,
  input wire logic rd_wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] host_dout,
  input wire logic dev_doe,
  input wire logic irq_n,
  input wire logic reset_n
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic hit;
  assign hit = addr inside {8'h80, 8'h81, 8'h82, 8'h83, 8'h88, 8'h89};
  chk_doe_when_sel: assert property (dev_doe |-> enable && rd_wr && hit)
    else $error("card drives data outside a selected read");
  chk_doe_on_hit: assert property (enable && rd_wr && hit |-> dev_doe)
    else $error("decoded read not driven");
  chk_unused_quiet: assert property (enable && addr inside {8'h8A, 8'h8B} |-> !dev_doe)
    else $error("unused location drives data");
  chk_write_no_drive: assert property (enable && !rd_wr |-> !dev_doe)
    else $error("card drives data during a write");
  chk_strobe_len: assert property ($rose(enable) |-> enable[*8] ##1 enable[*2] ##1 !enable)
    else $error("enable pulse length wrong");
  chk_sel_stable: assert property (enable && $past(enable) |-> $stable(addr) && $stable(rd_wr))
    else $error("selects moved within enable");
  chk_wdata_steady: assert property (enable && $past(enable) && !rd_wr |-> $stable(host_dout))
    else $error("write byte moved within enable");
  chk_reset_quiet: assert property ($rose(reset_n) |-> irq_n && !enable)
    else $error("bus not idle after reset");
  cover property (enable && rd_wr && hit);
  cover property ($rose(enable) && !rd_wr);
  cover property (!irq_n);
endmodule // dpa_chk_props

// File: test_dual_parallel_io_adapter.sv
/*
  Self-checking bench for host controller and card joined by the bus.
  Assumes the register map of the package header and a 50 ns clock.
*/
`timescale 1ns/100ps
`include "dpa_params.svh"
module test_dual_parallel_io_adapter;
  import dpa_pkg::*;
  logic hclk = 0, hresetn = 0, hwrite = 0, irq;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, irq1_in = 0, c2_in = 0, side_irq_n, c2o, c2e;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic hreadyout, hresp;
  logic [23:0] line_in = 0, line_out, line_oe, keep;
  logic [7:0] dir, dat, b;
  int err_total = 0, n_compared = 0, cyc = 0;
  dpa_bus_if bus ();
  dpa_host dpa_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .bus(bus));
  dpa_card dpa_card_i (.hclk(hclk), .hresetn(hresetn), .bus(bus), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe), .irq1_in(irq1_in), .ctrl2_in(c2_in),
    .ctrl2_out(c2o), .ctrl2_oe(c2e), .side_irq_n(side_irq_n));
  dpa_chk_props dpa_chk_props_i (.hclk(hclk), .hresetn(hresetn), .enable(bus.enable),
    .rd_wr(bus.rd_wr), .addr(bus.addr), .host_dout(bus.host_dout), .dev_doe(bus.dev_doe),
    .irq_n(bus.irq_n), .reset_n(bus.reset_n));
  always #25 hclk = ~hclk;
  // Data location read: input pins where the direction bit is 0, driven bits elsewhere
  function automatic logic [7:0] exp_data(input logic [7:0] pins, dr, o);
    return (pins & ~dr) | (o & dr);
  endfunction
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      err_total++;
      complete_run();
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // One adapter access through the command register, then fetch of the read byte
  task pa(input logic rd, input logic [7:0] a, input logic [7:0] d);
    ahb(1, `DPA_AHB_WDATA, {24'h0, d});
    ahb(1, `DPA_AHB_CMD, {22'h0, rd, 1'b1, a});
    do ahb(0, `DPA_AHB_STAT, 32'h0); while (r[0] !== 1'b0);
    ahb(0, `DPA_AHB_RDATA, 32'h0);
  endtask
  initial
  begin
    void'($urandom(82247));
    repeat (5) @(posedge hclk);
    hresetn <= 1;
    chk("oe", line_oe, 0);
    chk("irqn", side_irq_n, 7);
    ahb(1, `DPA_AHB_IRQ_MASK, 3);
    for (int p = 0; p < 3; p++)
    begin
      b = (p == 2) ? 8'h88 : 8'h80 + 8'(2 * p);
      dir = 8'($urandom);
      dat = 8'($urandom);
      line_in <= 24'($urandom);
      pa(0, b + 8'h01, `DPA_CTRL_INIT);
      pa(0, b, dir);
      chk("dir", line_oe[p*8+:8], dir);
      pa(0, b + 8'h01, `DPA_CTRL_RUN);
      pa(0, b, dat);
      chk("out", line_out[p*8+:8] & dir, dat & dir);
      pa(1, b, 0);
      chk("in", r[7:0], exp_data(line_in[p*8+:8], dir, dat));
      pa(1, b + 8'h01, 0);
      chk("ctrl", r[7:0], `DPA_CTRL_RUN);
    end
    keep = line_out;
    pa(0, 8'h8A, 8'hFF);
    pa(0, 8'h8B, 8'hFF);
    chk("unused", line_out, keep);
    pa(0, 8'h81, 8'h37);
    chk("c2oe", {c2e[0], c2o[0]}, 2'b10);
    pa(0, 8'h8A, 0);
    irq1_in[0] <= 1;
    repeat (3) @(posedge hclk);
    chk("flag", side_irq_n[0], 0);
    ahb(0, `DPA_AHB_IRQ_STAT, 0);
    chk("ist", r[1], 1);
    chk("irq", irq, 1);
    pa(1, 8'h80, 0);
    chk("clr", side_irq_n[0], 1);
    ahb(1, `DPA_AHB_IRQ_STAT, 3);
    ahb(0, `DPA_AHB_IRQ_STAT, 0);
    chk("w1c", r[1:0], 0);
    ahb(1, `DPA_AHB_IRQ_MASK, 0);
    pa(1, 8'h82, 0);
    chk("mask", irq, 0);
    ahb(0, `DPA_AHB_IRQ_STAT, 0);
    chk("done", r[0], 1);
    // Second interrupt line of side B on a rising edge, then a level output on side 2
    pa(0, 8'h83, 8'h1C);
    pa(0, 8'h8B, 0);
    c2_in[1] <= 1;
    repeat (3) @(posedge hclk);
    chk("flag2", side_irq_n[1], 0);
    pa(1, 8'h83, 0);
    chk("cr2", r[7:0], 8'h5C);
    pa(1, 8'h82, 0);
    chk("clr2", side_irq_n[1], 1);
    pa(0, 8'h89, 8'h3C);
    chk("c2lvl", {c2e[2], c2o[2]}, 2'b11);
    // Reset in mid-run returns every card register to zero; the host state register goes to DPA_IDLE
    @(posedge hclk);
    hresetn <= 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1;
    chk("rst_oe", line_oe, 0);
    chk("rst_out", {line_out, c2e, c2o}, 0);
    chk("rst_irq", {irq, side_irq_n}, 4'h7);
    pa(1, 8'h89, 0);
    chk("rst_cr", r[7:0], 0);
    complete_run();
  end
endmodule // test_dual_parallel_io_adapter
